// >>> edge_event_detect.sv
// per-bit edge detector for the interrupt inputs of the quasi port
`timescale 1ns/1ps
module edge_event_detect #(
  parameter int          WIDTH     = 4,
  parameter logic [3:0]  RISE_MASK = 4'h5
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [WIDTH-1:0]  level,
  output logic      [WIDTH-1:0]  edgeHit
);
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;
  logic [WIDTH-1:0] event_d;
  logic [WIDTH-1:0] event_q;

  // idle pin level is one, so a reset history of ones avoids a spurious edge
  always_comb
  begin
    prev_d = level;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (RISE_MASK[i])
        event_d[i] = level[i] & ~prev_q[i];
      else
        event_d[i] = ~level[i] & prev_q[i];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prev_q  <= '1;
      event_q <= '0;
    end
    else
    begin
      prev_q  <= prev_d;
      event_q <= event_d;
    end
  end

  assign edgeHit = event_q;
endmodule : edge_event_detect

// >>> far_side_model.sv
// outside circuits and memory on the port pins
`timescale 1ns/1ps
module far_side_model (
  input  logic       memDrive,
  input  logic [7:0] memData,
  input  logic [7:0] extPullLow,
  input  logic [7:0] quasiBidirPinOut,
  input  logic [7:0] quasiBidirPinOe,
  input  logic [7:0] lowAddrDataPinOut,
  input  logic [7:0] lowAddrDataPinOe,
  output logic [7:0] quasiBidirPinIn,
  output logic [7:0] lowAddrDataPinIn
);
  // an outside pull-down wins only over the weak pullup, never over strong drive
  assign quasiBidirPinIn = quasiBidirPinOut & (quasiBidirPinOe | ~extPullLow);
  // board pull-ups hold released low-port lines high; memory drives only in data phase
  assign lowAddrDataPinIn = (lowAddrDataPinOe & lowAddrDataPinOut)
    | (~lowAddrDataPinOe & (memDrive ? memData : 8'hFF));
endmodule : far_side_model

// >>> quasi_bidir_port_pins.sv
// pin logic of the open-drain address/data port and the quasi-bidirectional port
`timescale 1ns/1ps
// Notes on behaviour
// - As an external memory bus, the low port drives highs with its weak pullup enabled.
// - After reset every low port pin is released and drives neither level.
// - After reset all eight quasi port latch bits are one, weak pullup only.
// - A quasi pin whose latch is one is an input that an outside driver may pull low.
// - Writing zero to a quasi pin turns on a strong pulldown until a one is written or reset.
// - Writing one to a quasi pin that was zero gives a brief strong pull-high, then weak pullup.
// - Quasi bit 0 carries the timer two external input and output.
// - Quasi bit 1 is the timer two capture or reload trigger input.
// - Quasi bit 2 is the second serial port receive input.
// - Quasi bit 3 is the second serial port transmit output.
// - Quasi bit 4 is an external interrupt detected on a rising edge.
// - Quasi bit 5 is an external interrupt detected on a falling edge.
// - Quasi bit 6 is an external interrupt detected on a rising edge.
// - Quasi bit 7 is an external interrupt detected on a falling edge.
// - As general I/O the low port is an 8-bit open-drain bidirectional port.
// - During a memory access the low port shows the address while the strobe is high, then data.
module quasi_bidir_port_pins #(
  parameter int W = quasi_bidir_port_pkg::PORT_WIDTH
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // low address/data port, general I/O side
  input  wire logic          lowWrEn,
  input  wire logic [W-1:0]  lowWrData,
  output logic      [W-1:0]  lowPinLevel,
  // external memory side of the low port
  input  wire logic          extBusActive,
  input  wire logic          addrLatchStrobe,
  input  wire logic [W-1:0]  extAddrLow,
  input  wire logic          extDataDrive,
  input  wire logic [W-1:0]  extWrData,
  output logic      [W-1:0]  extRdData,
  // low port pins
  input  wire logic [W-1:0]  lowAddrDataPinIn,
  output logic      [W-1:0]  lowAddrDataPinOut,
  output logic      [W-1:0]  lowAddrDataPinOe,
  output logic      [W-1:0]  lowAddrDataWeakPullup,
  // quasi port, software side
  input  wire logic          qbWrEn,
  input  wire logic [W-1:0]  qbWrData,
  output logic      [W-1:0]  qbLatch,
  output logic      [W-1:0]  qbPinLevel,
  // quasi port pins: oe drives strong, out gives the level
  input  wire logic [W-1:0]  quasiBidirPinIn,
  output logic      [W-1:0]  quasiBidirPinOut,
  output logic      [W-1:0]  quasiBidirPinOe,
  output logic      [W-1:0]  quasiBidirWeakPullup,
  // alternate functions
  input  wire logic          timerTwoExtOut,
  output logic               timerTwoExtIn,
  output logic               timerTwoCaptureReloadTrigger,
  output logic               secondSerialReceive,
  input  wire logic          secondSerialTransmit,
  output logic               extIrqRisingA,
  output logic               extIrqFallingA,
  output logic               extIrqRisingB,
  output logic               extIrqFallingB
);
  localparam int PW = $clog2(quasi_bidir_port_pkg::STRONG_HIGH_CYC + 1);

  logic [W-1:0] lowLatch_q,  lowLatch_d;
  logic [W-1:0] lowOut_q,    lowOut_d;
  logic [W-1:0] lowOe_q,     lowOe_d;
  logic [W-1:0] lowWeak_q,   lowWeak_d;
  logic         lowUsed_q,   lowUsed_d;
  logic [W-1:0] lowIn_q,     lowIn_d;
  logic [W-1:0] qbLatch_q,   qbLatch_d;
  logic [W-1:0] qbOut_q,     qbOut_d;
  logic [W-1:0] qbOe_q,      qbOe_d;
  logic [W-1:0] qbIn_q,      qbIn_d;
  logic [PW-1:0] pulseCnt_q [W];
  logic [PW-1:0] pulseCnt_d [W];
  logic [W-1:0] altOut;
  logic [W-1:0] drive;
  logic [3:0]   irqEvents;

  // low port: open-drain I/O or multiplexed memory bus
  always_comb
  begin
    lowLatch_d = lowLatch_q;
    lowUsed_d  = lowUsed_q;
    lowIn_d    = lowAddrDataPinIn;
    if (lowWrEn)
    begin
      lowLatch_d = lowWrData;
      lowUsed_d  = 1'b1;
    end
    if (extBusActive && addrLatchStrobe)
    begin
      lowOut_d  = extAddrLow;
      lowOe_d   = '1;
      lowWeak_d = extAddrLow;
    end
    else if (extBusActive && extDataDrive)
    begin
      lowOut_d  = extWrData;
      lowOe_d   = '1;
      lowWeak_d = extWrData;
    end
    else if (extBusActive)
    begin
      lowOut_d  = '0;
      lowOe_d   = '0;
      lowWeak_d = '0;
    end
    else
    begin
      // open drain: only zeros drive; ones float for the external pullup
      lowOut_d  = '0;
      lowOe_d   = lowUsed_d ? ~lowLatch_d : '0;
      lowWeak_d = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lowLatch_q <= quasi_bidir_port_pkg::LOW_PORT_RST_OUT;
      lowOut_q   <= quasi_bidir_port_pkg::LOW_PORT_RST_OUT;
      lowOe_q    <= quasi_bidir_port_pkg::LOW_PORT_RST_OE;
      lowWeak_q  <= '0;
      lowUsed_q  <= 1'b0;
      lowIn_q    <= '0;
    end
    else
    begin
      lowLatch_q <= lowLatch_d;
      lowOut_q   <= lowOut_d;
      lowOe_q    <= lowOe_d;
      lowWeak_q  <= lowWeak_d;
      lowUsed_q  <= lowUsed_d;
      lowIn_q    <= lowIn_d;
    end
  end

  assign lowAddrDataPinOut     = lowOut_q;
  assign lowAddrDataPinOe      = lowOe_q;
  assign lowAddrDataWeakPullup = lowWeak_q;
  assign lowPinLevel           = lowIn_q;
  assign extRdData             = lowIn_q;

  // alternate outputs; only timer two and serial transmit drive pins
  always_comb
  begin
    altOut                                      = '1;
    altOut[quasi_bidir_port_pkg::BIT_T2_IO]     = timerTwoExtOut;
    altOut[quasi_bidir_port_pkg::BIT_SER_TX]    = secondSerialTransmit;
  end

  assign qbLatch_d = qbWrEn ? qbWrData : qbLatch_q;
  assign drive     = qbLatch_d & altOut;
  assign qbIn_d    = quasiBidirPinIn;

  // quasi port drivers, one per bit
  for (genvar b = 0; b < W; b++)
  begin : g_qb
    always_comb
    begin
      pulseCnt_d[b] = pulseCnt_q[b];
      qbOut_d[b]    = drive[b];
      qbOe_d[b]     = 1'b0;
      if (!drive[b])
      begin
        qbOe_d[b]     = 1'b1;
        pulseCnt_d[b] = '0;
      end
      else if (!qbOut_q[b])
      begin
        // zero to one: strong pull-high for a short burst to speed the edge
        qbOe_d[b]     = 1'b1;
        pulseCnt_d[b] = PW'(quasi_bidir_port_pkg::STRONG_HIGH_CYC - 1);
      end
      else if (pulseCnt_q[b] != '0)
      begin
        qbOe_d[b]     = 1'b1;
        pulseCnt_d[b] = pulseCnt_q[b] - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      qbLatch_q <= quasi_bidir_port_pkg::QB_LATCH_RST;
      qbOut_q   <= quasi_bidir_port_pkg::QB_LATCH_RST;
      qbOe_q    <= '0;
      qbIn_q    <= '1;
      for (int i = 0; i < W; i++)
        pulseCnt_q[i] <= '0;
    end
    else
    begin
      qbLatch_q <= qbLatch_d;
      qbOut_q   <= qbOut_d;
      qbOe_q    <= qbOe_d;
      qbIn_q    <= qbIn_d;
      for (int i = 0; i < W; i++)
        pulseCnt_q[i] <= pulseCnt_d[i];
    end
  end

  assign quasiBidirPinOut     = qbOut_q;
  assign quasiBidirPinOe      = qbOe_q;
  assign quasiBidirWeakPullup = qbOut_q;
  assign qbLatch              = qbLatch_q;
  assign qbPinLevel           = qbIn_q;

  assign timerTwoExtIn                = qbIn_q[quasi_bidir_port_pkg::BIT_T2_IO];
  assign timerTwoCaptureReloadTrigger = qbIn_q[quasi_bidir_port_pkg::BIT_T2_TRIG];
  assign secondSerialReceive          = qbIn_q[quasi_bidir_port_pkg::BIT_SER_RX];

  edge_event_detect #(
    .WIDTH     (4),
    .RISE_MASK (4'h5)
  ) u_irq_edges (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (qbIn_q[quasi_bidir_port_pkg::BIT_IRQ_FALL_B:quasi_bidir_port_pkg::BIT_IRQ_RISE_A]),
    .edgeHit (irqEvents)
  );

  assign extIrqRisingA  = irqEvents[0];
  assign extIrqFallingA = irqEvents[1];
  assign extIrqRisingB  = irqEvents[2];
  assign extIrqFallingB = irqEvents[3];
endmodule : quasi_bidir_port_pins

// >>> quasi_bidir_port_pins_sva.sv
// concurrent checks on the port pin block
`timescale 1ns/1ps
module quasi_bidir_port_pins_sva (
  input logic       clk_sys,
  input logic       rst,
  input logic       lowWrEn,
  input logic [7:0] lowWrData,
  input logic       extBusActive,
  input logic       addrLatchStrobe,
  input logic [7:0] extAddrLow,
  input logic [7:0] lowAddrDataPinOut,
  input logic [7:0] lowAddrDataPinOe,
  input logic [7:0] lowAddrDataWeakPullup,
  input logic       qbWrEn,
  input logic [7:0] qbWrData,
  input logic [7:0] qbLatch,
  input logic [7:0] qbPinLevel,
  input logic [7:0] quasiBidirPinIn,
  input logic [7:0] quasiBidirPinOut,
  input logic [7:0] quasiBidirPinOe,
  input logic       extIrqRisingA,
  input logic       extIrqFallingB
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_lowRst; $fell(rst) |-> lowAddrDataPinOe == 8'h00; endproperty
  a_lowRst: assert property (p_lowRst) else $error("low port driven after reset");
  property p_qbRst; $fell(rst) |-> qbLatch == 8'hFF && quasiBidirPinOe == 8'h00; endproperty
  a_qbRst: assert property (p_qbRst) else $error("quasi port not idle after reset");
  property p_sample; !$past(rst) |-> qbPinLevel == $past(quasiBidirPinIn); endproperty
  a_sample: assert property (p_sample) else $error("quasi pin sample wrong");
  // bits 0 and 3 are left out: a peripheral output may hold them low
  property p_pullDown; qbWrEn |=> (quasiBidirPinOe & ~quasiBidirPinOut & 8'hF6) == (~$past(qbWrData) & 8'hF6); endproperty
  a_pullDown: assert property (p_pullDown) else $error("strong pulldown wrong");
  property p_strongHigh; qbWrEn && qbWrData[7] && !qbLatch[7] |=> quasiBidirPinOe[7] && quasiBidirPinOut[7]
    ##1 !(quasiBidirPinOe[7] && quasiBidirPinOut[7]); endproperty
  a_strongHigh: assert property (p_strongHigh) else $error("strong pull-high wrong");
  property p_addr; extBusActive && addrLatchStrobe |=> lowAddrDataPinOe == 8'hFF
    && lowAddrDataPinOut == $past(extAddrLow) && lowAddrDataWeakPullup == $past(extAddrLow); endproperty
  a_addr: assert property (p_addr) else $error("address phase wrong");
  property p_lowIo; lowWrEn && !extBusActive |=> lowAddrDataPinOe == ~$past(lowWrData) && lowAddrDataPinOut == 8'h00;
  endproperty
  a_lowIo: assert property (p_lowIo) else $error("open-drain drive wrong");
  property p_irqRise; $rose(qbPinLevel[4]) |=> extIrqRisingA; endproperty
  a_irqRise: assert property (p_irqRise) else $error("rising event missed");
  property p_irqFall; $fell(qbPinLevel[7]) |=> extIrqFallingB; endproperty
  a_irqFall: assert property (p_irqFall) else $error("falling event missed");
  c_bus: cover property (extBusActive && addrLatchStrobe);
  c_high: cover property (qbWrEn && qbWrData[7] && !qbLatch[7]);
  c_irq: cover property (extIrqRisingA);
endmodule : quasi_bidir_port_pins_sva
bind quasi_bidir_port_pins quasi_bidir_port_pins_sva u_sva (
  .clk_sys               (clk_sys),
  .rst                   (rst),
  .lowWrEn               (lowWrEn),
  .lowWrData             (lowWrData),
  .extBusActive          (extBusActive),
  .addrLatchStrobe       (addrLatchStrobe),
  .extAddrLow            (extAddrLow),
  .lowAddrDataPinOut     (lowAddrDataPinOut),
  .lowAddrDataPinOe      (lowAddrDataPinOe),
  .lowAddrDataWeakPullup (lowAddrDataWeakPullup),
  .qbWrEn                (qbWrEn),
  .qbWrData              (qbWrData),
  .qbLatch               (qbLatch),
  .qbPinLevel            (qbPinLevel),
  .quasiBidirPinIn       (quasiBidirPinIn),
  .quasiBidirPinOut      (quasiBidirPinOut),
  .quasiBidirPinOe       (quasiBidirPinOe),
  .extIrqRisingA         (extIrqRisingA),
  .extIrqFallingB        (extIrqFallingB)
);

// >>> quasi_bidir_port_pkg.sv
// shared constants for the two port pin blocks
package quasi_bidir_port_pkg;
  localparam int          PORT_WIDTH        = 8;
  localparam logic [7:0]  LOW_PORT_RST_OUT  = 8'h00;
  localparam logic [7:0]  LOW_PORT_RST_OE   = 8'h00;
  localparam logic [7:0]  QB_LATCH_RST      = 8'hFF;
  localparam int          STRONG_HIGH_NS    = 100;
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          STRONG_HIGH_CYC   = (STRONG_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BIT_T2_IO         = 0;
  localparam int          BIT_T2_TRIG       = 1;
  localparam int          BIT_SER_RX        = 2;
  localparam int          BIT_SER_TX        = 3;
  localparam int          BIT_IRQ_RISE_A    = 4;
  localparam int          BIT_IRQ_FALL_A    = 5;
  localparam int          BIT_IRQ_RISE_B    = 6;
  localparam int          BIT_IRQ_FALL_B    = 7;
endpackage : quasi_bidir_port_pkg

// >>> tb_quasi_bidir_port_pins.sv
// self-checking bench for the port pin block
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin nErrors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_quasi_bidir_port_pins;
  typedef struct { string n; int s; logic [7:0] v; } note_t;
  logic        clk_sys = 1'b0, rst = 1'b1, lowWrEn = 1'b0, qbWrEn = 1'b0, memDrive = 1'b0;
  logic        extBusActive = 1'b0, addrLatchStrobe = 1'b0, extDataDrive = 1'b0;
  logic        timerTwoExtOut = 1'b1, secondSerialTransmit = 1'b1;
  logic [7:0]  lowWrData = 8'h00, extAddrLow = 8'h00, extWrData = 8'h00, qbWrData = 8'hFF;
  logic [7:0]  extPullLow = 8'h00, memData = 8'h00, d, prev;
  logic [7:0]  lowPinLevel, extRdData, lowAddrDataPinIn, lowAddrDataPinOut, lowAddrDataPinOe, lowAddrDataWeakPullup;
  logic [7:0]  qbLatch, qbPinLevel, quasiBidirPinIn, quasiBidirPinOut, quasiBidirPinOe, quasiBidirWeakPullup;
  logic        timerTwoExtIn, timerTwoCaptureReloadTrigger, secondSerialReceive;
  logic        extIrqRisingA, extIrqFallingA, extIrqRisingB, extIrqFallingB;
  logic [7:0]  ov [12];
  logic [31:0] seed = 32'hD546;
  int          nErrors = 0, numChecks = 0, cyc = 0;
  note_t       q[$];
  always #50 clk_sys = ~clk_sys;
  quasi_bidir_port_pins u_dut (.*);
  far_side_model u_far (.*);
  always_comb ov = '{lowAddrDataPinOe, lowAddrDataPinOut, lowAddrDataWeakPullup, qbLatch, quasiBidirPinOe,
    quasiBidirPinOut, extRdData, {4'h0, extIrqFallingB, extIrqRisingB, extIrqFallingA, extIrqRisingA},
    qbPinLevel, {5'h00, secondSerialReceive, timerTwoCaptureReloadTrigger, timerTwoExtIn}, lowPinLevel,
    quasiBidirWeakPullup};
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic note(input string n, input int s, input logic [7:0] v);
    q.push_back(note_t'{n, s, v});
  endtask : note
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // results are compared half a cycle after the edge that produced them
  always @(negedge clk_sys)
    while (q.size() > 0)
    begin
      `CHK(q[0].n, q[0].v, ov[q[0].s])
      void'(q.pop_front());
    end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 200)
    begin
      nErrors++;
      tally_and_finish();
    end
  end
  initial
  begin
    tick(3);
    rst = 1'b0;
    tick(1);
    note("lOe", 0, 8'h00);
    note("qLatch", 3, 8'hFF);
    note("qWeak", 11, 8'hFF);
    $display("end reset");
    prev = 8'hFF;
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      d = i[0] ? ~prev : seed[7:0];
      qbWrData = d;
      qbWrEn = 1'b1;
      tick(1);
      qbWrEn = 1'b0;
      note("qOe", 4, ~(d & prev));
      note("qOut", 5, d);
      note("qWeak", 11, d);
      tick(1);
      note("qOe", 4, ~d);
      prev = d;
    end
    qbWrData = 8'hFF;
    qbWrEn = 1'b1;
    timerTwoExtOut = 1'b0;
    secondSerialTransmit = 1'b0;
    tick(1);
    qbWrEn = 1'b0;
    tick(1);
    note("qOut", 5, 8'hF6);
    timerTwoExtOut = 1'b1;
    secondSerialTransmit = 1'b1;
    $display("end quasi drive");
    tick(3);
    seed = xs(seed);
    extPullLow = seed[7:0];
    tick(2);
    note("qPin", 8, ~extPullLow);
    note("alt", 9, {5'h00, ~extPullLow[2:0]});
    extPullLow = 8'h00;
    tick(3);
    extPullLow = 8'hF0;
    tick(2);
    note("irq", 7, 8'h0A);
    extPullLow = 8'h00;
    tick(2);
    note("irq", 7, 8'h05);
    $display("end quasi inputs");
    lowWrEn = 1'b1;
    repeat (3)
    begin
      seed = xs(seed);
      lowWrData = seed[7:0];
      tick(1);
      note("lOe", 0, ~lowWrData);
      note("lOut", 1, 8'h00);
    end
    lowWrEn = 1'b0;
    $display("end low io");
    seed = xs(seed);
    {memData, extWrData, extAddrLow} = seed[23:0];
    extBusActive = 1'b1;
    addrLatchStrobe = 1'b1;
    tick(1);
    note("bOe", 0, 8'hFF);
    note("bWeak", 2, extAddrLow);
    addrLatchStrobe = 1'b0;
    extDataDrive = 1'b1;
    tick(1);
    note("bOut", 1, extWrData);
    extDataDrive = 1'b0;
    memDrive = 1'b1;
    tick(2);
    note("bRd", 6, memData);
    note("lPin", 10, memData);
    memDrive = 1'b0;
    extBusActive = 1'b0;
    tick(1);
    $display("end memory bus");
    tally_and_finish();
  end
endmodule : tb_quasi_bidir_port_pins
